// ==== core/cell_balance_pkg.sv ====
package cell_balance_pkg;
    // data widths
    localparam int CELL_COUNT = 8;
    localparam int CELL_W = 12;
    localparam int TEMP_W = 12;
    localparam int RESULT_W = 14;
    localparam int CHAN_W = 4;
    localparam int GAIN_W = 2;
    localparam int TIME_W = 8;
    localparam int ADDR_W = 7;
    // voltage scaling of one cell code
    localparam int CELL_LSB_UV = 1172;
    localparam int BAL_HYST_MV = 117;
    localparam logic [CELL_W-1:0] HYST_CODE = CELL_W'((BAL_HYST_MV * 1000) / CELL_LSB_UV);
    // timing
    localparam int CLK_KHZ = 50000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_KHZ * TICK_MS;
    // serial target address; base value arbitrary
    localparam logic [ADDR_W-1:0] TARGET_ADDR_BASE = 7'h28;
    localparam int ADDR_SEL_BIT = 1;
    // pin synchroniser bit positions
    localparam int PIN_POS_SEL = 0;
    localparam int PIN_UNDERVOLTAGE_LOCKOUT = 1;
    localparam int PIN_COUNT = 2;
    // balance current mode
    typedef enum logic [1:0] {BAL_OFF, BAL_CHARGE, BAL_DISCHARGE, BAL_EOC} balance_mode_type;
    // host mode forcing commands
    typedef enum logic [2:0] {CMD_NONE, CMD_IDLE, CMD_DOZE, CMD_SLEEP, CMD_DOWN} power_cmd_type;
    // operating modes
    typedef enum logic [2:0] {PM_NORMAL, PM_IDLE, PM_DOZE, PM_SLEEP, PM_DOWN} power_mode_type;
endpackage

// ==== core/balance_interval_timer.sv ====
`timescale 1ns/1ns
module balance_interval_timer
    import cell_balance_pkg::*;
#(
    parameter int MS_CYCLES = TICK_CYCLES
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic [TIME_W-1:0] onTime,
    input wire logic [TIME_W-1:0] offTime,
    // phase
    output logic onPhase
);
    logic [$clog2(MS_CYCLES+1)-1:0] prescale;
    logic [TIME_W-1:0] msCount;
    logic msTick;
    logic phaseEnd;

    // one-millisecond tick; restarts with each run so the first on interval is whole
    assign msTick = (prescale == ($bits(prescale))'(MS_CYCLES - 1));
    assign phaseEnd = msTick && (msCount + 1'b1 >= (onPhase ? onTime : offTime));

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            prescale <= '0;
            msCount <= '0;
            onPhase <= 1'b1;
        end
        else
        begin
            prescale <= (msTick || !run) ? '0 : prescale + 1'b1;
            msCount <= (phaseEnd || !run) ? '0 : msCount + TIME_W'(msTick);
            onPhase <= run ? onPhase ^ phaseEnd : 1'b1;
        end
    end

    // a zero off time would starve the off interval; intervals last at least one tick
    chk_phase_hold: assert property (@(posedge sys_clk) disable iff (rst)
        run && !msTick && $past(run) |=> $stable(onPhase))
        else $error("balance phase moved without a millisecond tick");
endmodule

// ==== core/cell_balance_protection_ctrl.sv ====
// Contract
// - halt balancing when all cells beyond limits, except in end-of-charge mode
// - set cell fail on excessive cell spread
// - cell fail launches open-wire scan unless disabled
// - stop balancing outside balance temperature window
// - alternate balance on and off intervals
// - temperature limits use gain-converted value
// - FET-mode second sensor only turns FET off
// - cell fail sets pack shutdown when enabled
// - open wire sets pack shutdown when enabled
// - lockout powers device down when enabled
// - scan disable bit blocks open-wire scan
// - cascade position selects lower or upper unit
// - position select changes serial target address
// - charge mode balances only under charge current
// - discharge mode balances only under discharge current
// - end-of-charge balancing with 117 mV hysteresis
// - balance cells above lowest plus offset
// - host forces modes; only current restores normal
// - mode forcing needs no override bit
// - forced single conversion returns 14-bit result
`timescale 1ns/1ns
module cell_balance_protection_ctrl
    import cell_balance_pkg::*;
#(
    parameter int NCELL = CELL_COUNT,
    parameter int MS_CYCLES = TICK_CYCLES
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // measurements
    input wire logic [NCELL*CELL_W-1:0] cellVoltage,
    input wire logic [TEMP_W-1:0] temp1Raw,
    input wire logic [TEMP_W-1:0] temp2Raw,
    input wire logic chargeDetect,
    input wire logic dischargeDetect,
    // balance configuration
    input wire balance_mode_type balanceMode,
    input wire logic [CELL_W-1:0] balanceUpperLimit,
    input wire logic [CELL_W-1:0] balanceLowerLimit,
    input wire logic [CELL_W-1:0] eocThreshold,
    input wire logic [CELL_W-1:0] max_spread_limit,
    input wire logic [CELL_W-1:0] balance_offset,
    input wire logic [TIME_W-1:0] balance_on_time,
    input wire logic [TIME_W-1:0] balance_off_time,
    // temperature configuration
    input wire logic temp_input_gain,
    input wire logic [TEMP_W:0] balanceOverTemp,
    input wire logic [TEMP_W:0] balanceUnderTemp,
    input wire logic [TEMP_W:0] packOverTemp,
    input wire logic [TEMP_W:0] packRecoverTemp,
    input wire logic second_temp_input,
    // pack options
    input wire logic cellFailShutdownEn,
    input wire logic openWireShutdownEn,
    input wire logic uvloPowerDownEn,
    input wire logic openWireScanDisable,
    input wire logic cascadeEn,
    // pins from outside the clock domain
    input wire logic positionSelectPin,
    input wire logic undervoltage_lockout,
    // host controls
    input wire logic cellFailClear,
    input wire logic packShutdownSet,
    input wire logic packShutdownClear,
    input wire logic openWireManualStart,
    input wire logic openWireDetect,
    input wire logic modeCmdValid,
    input wire power_cmd_type modeCmd,
    input wire logic measureWrite,
    input wire logic [CHAN_W-1:0] measureChannelWrite,
    input wire logic conversion_start,
    input wire logic [GAIN_W-1:0] currentGainWrite,
    // converter front end
    input wire logic adcDone,
    input wire logic [RESULT_W-1:0] adcData,
    // status and controls out
    output logic cell_fail_flag,
    output logic pack_shutdown,
    output logic openWireStart,
    output logic [NCELL-1:0] balanceOut,
    output logic balanceHalted,
    output logic powerFetOff,
    output logic currentSenseOff,
    output logic fetDriveEn,
    output logic [ADDR_W-1:0] targetAddr,
    output power_mode_type powerMode,
    output logic modeForced,
    output logic powerDown,
    // forced measurement
    output logic [CHAN_W-1:0] measure_channel_select,
    output logic [GAIN_W-1:0] ampGain,
    output logic adcRequest,
    output logic convBusy,
    output logic convValid,
    output logic [RESULT_W-1:0] convResult
);
    logic [PIN_COUNT-1:0] pinMeta, pinSync;
    logic eocActive, packHot;
    logic [NCELL-1:0] aboveOffset, overUpper, underLower, insideUpper, insideLower, atEoc, overEocHyst;
    logic [CELL_W-1:0] highest_cell_voltage, lowest_cell_voltage;
    power_mode_type next_mode;
    // pins pass two flops; only the second stage feeds logic
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pinMeta <= '0;
            pinSync <= '0;
        end
        else
        begin
            pinMeta <= {undervoltage_lockout, positionSelectPin};
            pinSync <= pinMeta;
        end
    end
    // extremes across the stack
    function automatic logic [CELL_W-1:0] pick(input logic [NCELL*CELL_W-1:0] v, input logic findMax);
        logic [CELL_W-1:0] best;
        best = v[CELL_W-1:0];
        for (int i = 1; i < NCELL; i++)
            if (findMax ? (v[i*CELL_W +: CELL_W] > best) : (v[i*CELL_W +: CELL_W] < best))
                best = v[i*CELL_W +: CELL_W];
        return best;
    endfunction
    assign highest_cell_voltage = pick(cellVoltage, 1'b1);
    assign lowest_cell_voltage = pick(cellVoltage, 1'b0);
    // per-cell comparisons; one extra bit so sums never wrap
    generate
        for (genvar g = 0; g < NCELL; g++)
        begin : cellCmp
            wire [CELL_W:0] v = {1'b0, cellVoltage[g*CELL_W +: CELL_W]};
            assign aboveOffset[g] = v > {1'b0, lowest_cell_voltage} + {1'b0, balance_offset};
            assign overUpper[g] = v > {1'b0, balanceUpperLimit};
            assign underLower[g] = v < {1'b0, balanceLowerLimit};
            assign insideUpper[g] = v + {1'b0, HYST_CODE} < {1'b0, balanceUpperLimit};
            assign insideLower[g] = v > {1'b0, balanceLowerLimit} + {1'b0, HYST_CODE};
            assign atEoc[g] = v >= {1'b0, eocThreshold};
            assign overEocHyst[g] = v + {1'b0, HYST_CODE} > {1'b0, eocThreshold};
        end
    endgenerate
    // spread, limits and temperature decisions
    wire [CELL_W-1:0] spread = highest_cell_voltage - lowest_cell_voltage;
    wire spreadOver = spread > max_spread_limit;
    wire allBeyond = (&overUpper) || (&underLower);
    wire allInside = (&insideUpper) && (&insideLower);
    // amplifier gain doubles the code, so thresholds must follow the same scale
    wire [TEMP_W:0] temp1Conv = temp_input_gain ? {temp1Raw, 1'b0} : {1'b0, temp1Raw};
    wire [TEMP_W:0] temp2Conv = temp_input_gain ? {temp2Raw, 1'b0} : {1'b0, temp2Raw};
    wire temp1InWindow = temp1Conv <= balanceOverTemp && temp1Conv >= balanceUnderTemp;
    wire temp2InWindow = temp2Conv <= balanceOverTemp && temp2Conv >= balanceUnderTemp;
    wire tempOk = temp1InWindow && (second_temp_input || temp2InWindow);
    wire anyHot = temp1Conv > packOverTemp || temp2Conv > packOverTemp;
    wire allCool = temp1Conv < packRecoverTemp && temp2Conv < packRecoverTemp;
    // current direction gate per balance mode
    wire chargeOnly = chargeDetect && !dischargeDetect;
    wire dischargeOnly = dischargeDetect && !chargeDetect;
    wire modeOk = (balanceMode == BAL_CHARGE && chargeOnly)
        || (balanceMode == BAL_DISCHARGE && dischargeOnly)
        || (balanceMode == BAL_EOC && eocActive);
    wire limitHaltApplies = balanceMode != BAL_EOC && balanceHalted;
    wire balanceAllowed = modeOk && tempOk && !limitHaltApplies && !cell_fail_flag;
    wire onPhase;
    balance_interval_timer #(
        .MS_CYCLES(MS_CYCLES)
    ) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(balanceAllowed),
        .onTime(balance_on_time),
        .offTime(balance_off_time),
        .onPhase(onPhase)
    );
    // next values of the protection flags; a set always beats a clear
    wire next_cellFail = spreadOver || (cell_fail_flag && !cellFailClear);
    wire psdCause = (cellFailShutdownEn && spreadOver)
        || (openWireShutdownEn && openWireDetect) || packShutdownSet;
    wire next_packShutdown = psdCause || (pack_shutdown && !packShutdownClear);
    wire next_owStart = !openWireScanDisable
        && ((spreadOver && !cell_fail_flag) || openWireManualStart);
    wire next_halted = allBeyond || (balanceHalted && !allInside);
    wire next_eoc = (|atEoc) || (eocActive && (|overEocHyst));
    wire next_hot = anyHot || (packHot && !allCool);
    wire [NCELL-1:0] next_balance = (balanceAllowed && onPhase) ? aboveOffset : '0;
    wire lowerUnit = cascadeEn && pinSync[PIN_POS_SEL];
    // flags, fet and cascade roles, operating mode
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cell_fail_flag <= 1'b0;
            pack_shutdown <= 1'b0;
            openWireStart <= 1'b0;
            balanceHalted <= 1'b0;
            eocActive <= 1'b0;
            packHot <= 1'b0;
            balanceOut <= '0;
            powerFetOff <= 1'b1;
            currentSenseOff <= 1'b0;
            fetDriveEn <= 1'b0;
            targetAddr <= TARGET_ADDR_BASE;
            powerMode <= PM_NORMAL;
            modeForced <= 1'b0;
            powerDown <= 1'b0;
        end
        else
        begin
            cell_fail_flag <= next_cellFail;
            pack_shutdown <= next_packShutdown;
            openWireStart <= next_owStart;
            balanceHalted <= next_halted;
            eocActive <= next_eoc;
            packHot <= next_hot;
            balanceOut <= next_balance;
            powerFetOff <= packHot || lowerUnit;
            currentSenseOff <= lowerUnit;
            fetDriveEn <= !lowerUnit;
            targetAddr <= TARGET_ADDR_BASE | (ADDR_W'(pinSync[PIN_POS_SEL]) << ADDR_SEL_BIT);
            powerMode <= next_mode;
            modeForced <= (next_mode == PM_NORMAL) ? 1'b0 : (modeCmdValid ? modeCmd != CMD_NONE : modeForced);
            powerDown <= next_mode == PM_DOWN;
        end
    end
    // operating mode; no override bit gates the host command
    always_comb
    begin
        next_mode = powerMode;
        if (uvloPowerDownEn && pinSync[PIN_UNDERVOLTAGE_LOCKOUT])
            next_mode = PM_DOWN;
        else if (powerMode != PM_DOWN && (chargeDetect || dischargeDetect))
            next_mode = PM_NORMAL;
        else if (modeCmdValid)
        begin
            case (modeCmd)
                CMD_IDLE: next_mode = PM_IDLE;
                CMD_DOZE: next_mode = PM_DOZE;
                CMD_SLEEP: next_mode = PM_SLEEP;
                CMD_DOWN: next_mode = PM_DOWN;
                default: next_mode = powerMode; // clearing a force never restores normal
            endcase
        end
    end
    // forced single conversion; a start while busy is dropped
    wire convLaunch = measureWrite && conversion_start && !convBusy;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            measure_channel_select <= '0;
            ampGain <= '0;
            adcRequest <= 1'b0;
            convBusy <= 1'b0;
            convValid <= 1'b0;
            convResult <= '0;
        end
        else
        begin
            if (measureWrite && !convBusy)
            begin
                measure_channel_select <= measureChannelWrite;
                ampGain <= currentGainWrite;
            end
            adcRequest <= convLaunch;
            convBusy <= convLaunch || (convBusy && !adcDone);
            convValid <= convBusy && adcDone;
            if (convBusy && adcDone)
                convResult <= adcData;
        end
    end
    // checks
    sequence spreadSeen;
        spreadOver;
    endsequence
    sequence convIssued;
        convLaunch ##1 (adcRequest && convBusy);
    endsequence
    chk_spread_flag: assert property (@(posedge sys_clk) disable iff (rst)
        spreadSeen |=> cell_fail_flag)
        else $error("cell fail not set on excessive spread");
    chk_ow_launch: assert property (@(posedge sys_clk) disable iff (rst)
        spreadSeen ##0 (!cell_fail_flag && !openWireScanDisable) |=> openWireStart && cell_fail_flag)
        else $error("open-wire scan not launched by cell fail");
    chk_ow_disable: assert property (@(posedge sys_clk) disable iff (rst)
        openWireScanDisable |=> !openWireStart)
        else $error("open-wire scan started while disabled");
    chk_psd_cellfail: assert property (@(posedge sys_clk) disable iff (rst)
        cellFailShutdownEn && spreadOver |=> pack_shutdown && cell_fail_flag)
        else $error("pack shutdown missing on cell fail");
    chk_psd_openwire: assert property (@(posedge sys_clk) disable iff (rst)
        openWireShutdownEn && openWireDetect |=> pack_shutdown)
        else $error("pack shutdown missing on open wire");
    chk_undervoltage_lockout_down: assert property (@(posedge sys_clk) disable iff (rst)
        uvloPowerDownEn && undervoltage_lockout [*3] |=> powerDown)
        else $error("lockout did not power down");
    chk_bal_charge: assert property (@(posedge sys_clk) disable iff (rst)
        balanceMode == BAL_CHARGE && !chargeOnly |=> balanceOut == '0)
        else $error("balancing without charge current");
    chk_bal_discharge: assert property (@(posedge sys_clk) disable iff (rst)
        balanceMode == BAL_DISCHARGE && !dischargeOnly |=> balanceOut == '0)
        else $error("balancing without discharge current");
    chk_bal_temp: assert property (@(posedge sys_clk) disable iff (rst)
        !temp1InWindow |=> balanceOut == '0)
        else $error("balancing outside temperature window");
    chk_bal_halt: assert property (@(posedge sys_clk) disable iff (rst)
        balanceMode != BAL_EOC && balanceHalted |=> balanceOut == '0)
        else $error("balancing while all cells beyond limits");
    chk_mode_stay: assert property (@(posedge sys_clk) disable iff (rst)
        powerMode != PM_NORMAL && !chargeDetect && !dischargeDetect |=> powerMode != PM_NORMAL)
        else $error("normal mode restored without current");
    chk_conv_result: assert property (@(posedge sys_clk) disable iff (rst)
        convIssued ##[0:1000] (convBusy && adcDone) |=> convValid && convResult == $past(adcData))
        else $error("conversion result not returned");
    chk_cascade_addr: assert property (@(posedge sys_clk) disable iff (rst)
        cascadeEn && pinSync[PIN_POS_SEL] [*2] |-> !fetDriveEn && currentSenseOff && targetAddr[ADDR_SEL_BIT])
        else $error("lower unit role not applied");
endmodule

// ==== dv/adc_front_model.sv ====
`timescale 1ns/1ns
module adc_front_model
    import cell_balance_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // request side
    input wire logic adcRequest,
    input wire logic [CHAN_W-1:0] measure_channel_select,
    input wire logic slow,
    // answer side
    output logic adcDone,
    output logic [RESULT_W-1:0] adcData
);
    logic [4:0] waitCnt;
    logic [RESULT_W-1:0] churn;
    // one answer per request, after a short or a long conversion
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            waitCnt <= 5'h0;
            adcDone <= 1'h0;
            churn <= 14'h0000;
        end
        else
        begin
            churn <= churn + 14'h1357;
            adcDone <= waitCnt == 5'h01;
            waitCnt <= adcRequest ? (slow ? 5'h0d : 5'h02) : waitCnt - 5'(waitCnt != 5'h00);
        end
    end
    // data is valid only with done
    assign adcData = adcDone ? {measure_channel_select, 10'h15a} : churn;
endmodule

// ==== dv/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    import cell_balance_pkg::*;
    localparam int MS = 4;
    // stimulus
    logic sys_clk, rst = 1'h1;
    logic [CELL_COUNT*CELL_W-1:0] cellVoltage;
    logic [CELL_W-1:0] cv [CELL_COUNT];
    logic [TEMP_W-1:0] temp1Raw = 12'h0400, temp2Raw = 12'h0400;
    logic chargeDetect = 1'h0, dischargeDetect = 1'h0, temp_input_gain = 1'h0, second_temp_input = 1'h0;
    balance_mode_type balanceMode = BAL_OFF;
    logic [CELL_W-1:0] balanceUpperLimit = 12'h0d00, balanceLowerLimit = 12'h0800, eocThreshold = 12'h0c00;
    logic [CELL_W-1:0] max_spread_limit = 12'h0300, balance_offset = 12'h0010;
    logic [TIME_W-1:0] balance_on_time = 8'h14, balance_off_time = 8'h03;
    logic [TEMP_W:0] balanceOverTemp = 13'h0800, balanceUnderTemp = 13'h0100;
    logic [TEMP_W:0] packOverTemp = 13'h0900, packRecoverTemp = 13'h0700;
    logic cellFailShutdownEn = 1'h1, openWireShutdownEn = 1'h0, uvloPowerDownEn = 1'h0, openWireScanDisable = 1'h0;
    logic cascadeEn = 1'h0, positionSelectPin = 1'h0, undervoltage_lockout = 1'h0, cellFailClear = 1'h0;
    logic packShutdownSet = 1'h0, packShutdownClear = 1'h0, openWireManualStart = 1'h0, openWireDetect = 1'h0;
    logic modeCmdValid = 1'h0, measureWrite = 1'h0, conversion_start = 1'h0, slow = 1'h0;
    power_cmd_type modeCmd = CMD_NONE;
    logic [CHAN_W-1:0] measureChannelWrite = 4'h0;
    logic [GAIN_W-1:0] currentGainWrite = 2'h0;
    // observed
    logic adcDone, cell_fail_flag, pack_shutdown, openWireStart, balanceHalted, powerFetOff;
    logic currentSenseOff, fetDriveEn, modeForced, powerDown, adcRequest, convBusy, convValid;
    logic [RESULT_W-1:0] adcData, convResult;
    logic [CELL_COUNT-1:0] balanceOut;
    logic [ADDR_W-1:0] targetAddr;
    power_mode_type powerMode;
    logic [CHAN_W-1:0] measure_channel_select;
    logic [GAIN_W-1:0] ampGain;
    int n_errors = 0, samples_checked = 0;
    cell_balance_protection_ctrl #(.MS_CYCLES(MS)) dut_u (.sys_clk, .rst, .cellVoltage, .temp1Raw, .temp2Raw,
        .chargeDetect, .dischargeDetect, .balanceMode, .balanceUpperLimit, .balanceLowerLimit, .eocThreshold,
        .max_spread_limit, .balance_offset, .balance_on_time, .balance_off_time, .temp_input_gain,
        .balanceOverTemp, .balanceUnderTemp, .packOverTemp, .packRecoverTemp, .second_temp_input,
        .cellFailShutdownEn, .openWireShutdownEn, .uvloPowerDownEn, .openWireScanDisable, .cascadeEn,
        .positionSelectPin, .undervoltage_lockout, .cellFailClear, .packShutdownSet, .packShutdownClear,
        .openWireManualStart, .openWireDetect, .modeCmdValid, .modeCmd, .measureWrite, .measureChannelWrite,
        .conversion_start, .currentGainWrite, .adcDone, .adcData, .cell_fail_flag, .pack_shutdown,
        .openWireStart, .balanceOut, .balanceHalted, .powerFetOff, .currentSenseOff, .fetDriveEn, .targetAddr,
        .powerMode, .modeForced, .powerDown, .measure_channel_select, .ampGain, .adcRequest, .convBusy,
        .convValid, .convResult);
    adc_front_model far_u (.sys_clk, .rst, .adcRequest, .measure_channel_select, .slow, .adcDone, .adcData);
    // free-running clock
    initial
    begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    // cell array packed onto the wide port
    always_comb
        for (int i = 0; i < CELL_COUNT; i++)
            cellVoltage[i*CELL_W +: CELL_W] = cv[i];
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // a bounded wait that ran out
    task automatic expire();
        n_errors++;
        wrap_up();
    endtask
    task automatic set_cells(input logic [CELL_W-1:0] v, d);
        foreach (cv[i]) cv[i] = v;
        cv[2] = v + d;
        cv[5] = v + (d >> 1);
    endtask
    // cells above the lowest cell plus the offset
    function automatic logic [CELL_COUNT-1:0] want();
        logic [CELL_W-1:0] lo;
        lo = cv[0];
        foreach (cv[i]) if (cv[i] < lo) lo = cv[i];
        foreach (cv[i]) want[i] = cv[i] > lo + balance_offset;
    endfunction
    // off first, so the timer restarts on
    task automatic bal(input balance_mode_type m, input logic c, d, on);
        balanceMode = BAL_OFF;
        step(2);
        balanceMode = m;
        chargeDetect = c;
        dischargeDetect = d;
        step(3);
        chk(balanceOut, on ? want() : 8'h00);
    endtask
    task automatic bal_chg(input logic on);
        bal(BAL_CHARGE, 1'h1, 1'h0, on);
    endtask
    task automatic clear_flags();
        cellFailClear = 1'h1;
        packShutdownClear = 1'h1;
        step(1);
        cellFailClear = 1'h0;
        packShutdownClear = 1'h0;
        step(2);
    endtask
    task automatic bal_modes();
        set_cells(12'h0a00, 12'h0040);
        bal_chg(1'h1);
        bal(BAL_CHARGE, 1'h0, 1'h1, 1'h0);
        bal(BAL_CHARGE, 1'h0, 1'h0, 1'h0);
        bal(BAL_DISCHARGE, 1'h0, 1'h1, 1'h1);
        bal(BAL_DISCHARGE, 1'h1, 1'h0, 1'h0);
        bal(BAL_EOC, 1'h0, 1'h0, 1'h0);
        cv[2] = 12'h0c08;
        bal(BAL_EOC, 1'h0, 1'h1, 1'h1);
        cv[2] = 12'h0bb0;
        step(3);
        chk(balanceOut, want());
        cv[2] = 12'h0b90;
        step(3);
        chk(balanceOut, 8'h00);
    endtask
    task automatic temps();
        set_cells(12'h0a00, 12'h0040);
        temp1Raw = 12'h0900;
        bal_chg(1'h0);
        temp1Raw = 12'h0080;
        bal_chg(1'h0);
        temp1Raw = 12'h0500;
        temp_input_gain = 1'h1;
        bal_chg(1'h0);
        temp_input_gain = 1'h0;
        bal_chg(1'h1);
        temp2Raw = 12'h0a00;
        second_temp_input = 1'h1;
        bal_chg(1'h1);
        chk(powerFetOff, 1'h1);
        second_temp_input = 1'h0;
        bal_chg(1'h0);
        temp2Raw = 12'h0400;
    endtask
    task automatic halt_and_phases();
        int k;
        set_cells(12'h0d10, 12'h0020);
        bal_chg(1'h0);
        chk(balanceHalted, 1'h1);
        set_cells(12'h0cb0, 12'h0020);
        step(3);
        chk(balanceHalted, 1'h1);
        set_cells(12'h0c60, 12'h0020);
        step(3);
        chk(balanceHalted, 1'h0);
        chk(balanceOut, want());
        balance_on_time = 8'h02;
        bal_chg(1'h1);
        for (k = 0; balanceOut !== 8'h00 && k < 40; k++) step(1);
        for (k = 0; balanceOut === 8'h00 && k < 40; k++) step(1);
        chk(k, balance_off_time * MS);
        for (k = 0; balanceOut !== 8'h00 && k < 40; k++) step(1);
        chk(k, balance_on_time * MS);
    endtask
    task automatic spread();
        int k;
        set_cells(12'h0a00, 12'h0040);
        cv[7] = 12'h0d10;
        for (k = 0; openWireStart !== 1'h1 && k < 10; k++) step(1);
        if (k == 10) expire();
        chk(cell_fail_flag, 1'h1);
        chk(pack_shutdown, 1'h1);
        step(1);
        chk(openWireStart, 1'h0);
        cv[7] = 12'h0a00;
        clear_flags();
        chk(cell_fail_flag, 1'h0);
        openWireScanDisable = 1'h1;
        cellFailShutdownEn = 1'h0;
        openWireManualStart = 1'h1;
        cv[7] = 12'h0d10;
        for (k = 0; k < 4; k++)
        begin
            step(1);
            chk(openWireStart, 1'h0);
        end
        chk(cell_fail_flag, 1'h1);
        chk(pack_shutdown, 1'h0);
        openWireShutdownEn = 1'h1;
        openWireDetect = 1'h1;
        step(3);
        chk(pack_shutdown, 1'h1);
        openWireDetect = 1'h0;
        openWireManualStart = 1'h0;
        openWireScanDisable = 1'h0;
        cv[7] = 12'h0a00;
        clear_flags();
    endtask
    // a write while busy leaves the select alone
    task automatic conv(input logic [CHAN_W-1:0] ch, input logic s);
        int k;
        slow = s;
        measureChannelWrite = ch;
        currentGainWrite = ch[1:0];
        conversion_start = 1'h1;
        measureWrite = 1'h1;
        step(1);
        measureWrite = 1'h0;
        for (k = 0; adcRequest !== 1'h1 && k < 5; k++) step(1);
        if (k == 5) expire();
        chk(measure_channel_select, ch);
        chk(ampGain, ch[1:0]);
        chk(convBusy, 1'h1);
        measureChannelWrite = ~ch;
        measureWrite = 1'h1;
        step(1);
        measureWrite = 1'h0;
        chk(measure_channel_select, ch);
        for (k = 0; convValid !== 1'h1 && k < 30; k++) step(1);
        if (k == 30) expire();
        chk(convResult, {ch, 10'h15a});
        chk(convBusy, 1'h0);
    endtask
    task automatic mode_cmd(input power_cmd_type c);
        modeCmd = c;
        modeCmdValid = 1'h1;
        step(1);
        modeCmdValid = 1'h0;
        step(1);
    endtask
    task automatic modes();
        chargeDetect = 1'h0;
        dischargeDetect = 1'h0;
        for (int i = 1; i < 4; i++)
        begin
            mode_cmd(power_cmd_type'(i));
            chk(powerMode, i);
            chk(modeForced, 1'h1);
        end
        mode_cmd(CMD_NONE);
        chk(powerMode, PM_SLEEP);
        chk(modeForced, 1'h0);
        chargeDetect = 1'h1;
        step(3);
        chk(powerMode, PM_NORMAL);
        chargeDetect = 1'h0;
        mode_cmd(CMD_DOWN);
        dischargeDetect = 1'h1;
        step(3);
        chk(powerMode, PM_DOWN);
        dischargeDetect = 1'h0;
    endtask
    task automatic pins();
        cascadeEn = 1'h1;
        positionSelectPin = 1'h1;
        undervoltage_lockout = 1'h1;
        step(5);
        chk(currentSenseOff, 1'h1);
        chk(fetDriveEn, 1'h0);
        chk(targetAddr, TARGET_ADDR_BASE | 7'(1 << ADDR_SEL_BIT));
        chk(powerDown, 1'h0);
        positionSelectPin = 1'h0;
        uvloPowerDownEn = 1'h1;
        step(5);
        chk(currentSenseOff, 1'h0);
        chk(targetAddr, TARGET_ADDR_BASE);
        chk(powerDown, 1'h1);
        undervoltage_lockout = 1'h0;
    endtask
    // reset again mid-run to leave power-down
    initial
    begin
        set_cells(12'h0a00, 12'h0040);
        step(5);
        chk(targetAddr, TARGET_ADDR_BASE);
        chk(powerMode, PM_NORMAL);
        rst = 1'h0;
        step(3);
        bal_modes();
        temps();
        halt_and_phases();
        spread();
        conv(4'h5, 1'h0);
        conv(4'ha, 1'h1);
        modes();
        rst = 1'h1;
        step(5);
        rst = 1'h0;
        step(3);
        pins();
        wrap_up();
    end
endmodule
